// >>> bench/obj_feeder.sv
`timescale 1ns/100ps
module obj_feeder (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    int gap = 0;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    // ------------------------------------------------------------
    // One transfer; released lines show inverted data
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// >>> bench/output_time_and_scene_control_asserts.sv
`timescale 1ns/100ps
module output_time_and_scene_control_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic relay_on
);
    // ------------------------------------------------------------
    // Mode tracking from control writes
    // ------------------------------------------------------------
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic wr;
    logic rd;
    logic perm_wr;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign perm_wr = wr && paddr == out_time_pkg::object_off && pwdata[17];
    always_comb
    begin
        mode_next = mode_reg;
        if (wr && paddr == out_time_pkg::ctrl_off)
        begin
            mode_next = pwdata[1:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= 2'h0;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ready_high_a: assert property (psel |-> pready) else $error("pready low");
    no_error_a: assert property (psel |-> !pslverr) else $error("pslverr high");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    unmapped_zero_a: assert property (rd && paddr == 12'hFFC |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    pulse_zero_a: assert property (rd && paddr == out_time_pkg::ctrl_off
        |=> prdata[10:8] == 3'h0) else $error("pulse bits read back");
    slot_range_a: assert property (rd && paddr >= out_time_pkg::slot_base_off
        && paddr <= out_time_pkg::slot_top_off |=> prdata[6:0] <= out_time_pkg::scene_max)
        else $error("slot scene number out of range");
    override_on_a: assert property (perm_wr && pwdata[1] |-> ##[1:2] relay_on)
        else $error("override did not drive relay");
    override_off_a: assert property (perm_wr && !pwdata[1] && mode_reg == 2'h1
        |-> ##[1:2] !relay_on) else $error("override end kept relay");
    restart_hold_a: assert property (perm_wr && !pwdata[1] && mode_reg == 2'h3
        |-> ##1 relay_on [*4]) else $error("restart dropped relay");
    cover property (perm_wr && pwdata[1]);
    cover property (perm_wr && !pwdata[1] && mode_reg == 2'h3);
    cover property (rd && paddr == out_time_pkg::slot_base_off);
endmodule

bind output_time_and_scene_control output_time_and_scene_control_asserts u_asserts (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .relay_on(relay_on)
);

// >>> bench/output_time_and_scene_control_tb_top.sv
`timescale 1ns/100ps
module output_time_and_scene_control_tb_top;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic relay_on;
    int n_mismatch;
    int n_checks;
    int cyc;
    logic [31:0] rd;
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    obj_feeder u_obj_feeder (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
    // Short tick keeps second-scale delays to tens of cycles
    output_time_and_scene_control #(.tick_cycles(10)) u_output_time_and_scene_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .relay_on(relay_on));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_obj_feeder.xfer(1'b1, a, d, rd);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        u_obj_feeder.xfer(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask
    task automatic obj(input logic [31:0] d);
        wr(out_time_pkg::object_off, d);
    endtask
    task automatic ctl(input logic [31:0] d);
        wr(out_time_pkg::ctrl_off, d);
    endtask
    // Waits up to n cycles for the relay level, then compares
    task automatic see(input logic exp, input int n);
        int i;
        i = 0;
        @(negedge pclk);
        while (relay_on !== exp && i < n)
        begin
            @(negedge pclk);
            i++;
        end
        chk({31'h0, relay_on}, {31'h0, exp});
    endtask
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals;
        u_obj_feeder.gap = 3;
        rchk(out_time_pkg::ctrl_off, 32'h0C);
        rchk(out_time_pkg::on_delay_off, 32'h5);
        rchk(out_time_pkg::off_delay_off, 32'h5);
        rchk(out_time_pkg::stair_time_off, 32'h1E);
        for (int i = 0; i < 8; i++)
        begin
            rchk(out_time_pkg::slot_base_off + 12'(4 * i), 32'h300);
        end
        u_obj_feeder.gap = 0;
        wr(12'hFFC, 32'hFFFF_FFFF);
        rchk(12'hFFC, 32'h0);
    endtask
    task automatic t_delays;
        wr(out_time_pkg::on_delay_off, 32'h4);
        wr(out_time_pkg::off_delay_off, 32'h4);
        obj(32'h0001_0001);
        repeat (15) @(posedge pclk);
        see(1'b0, 0);
        see(1'b1, 40);
        obj(32'h0001_0000);
        repeat (20) @(posedge pclk);
        obj(32'h0001_0000);
        repeat (22) @(posedge pclk);
        see(1'b1, 0);
        see(1'b0, 25);
        ctl(32'h08);
        obj(32'h0001_0001);
        repeat (20) @(posedge pclk);
        obj(32'h0001_0001);
        see(1'b1, 22);
        ctl(32'h0C);
    endtask
    task automatic t_override;
        wr(out_time_pkg::stair_time_off, 32'h3);
        ctl(32'h0D);
        obj(32'h0002_0002);
        see(1'b1, 3);
        obj(32'h0001_0000);
        repeat (50) @(posedge pclk);
        see(1'b1, 0);
        obj(32'h0002_0000);
        see(1'b0, 3);
        ctl(32'h0F);
        obj(32'h0002_0002);
        obj(32'h0002_0000);
        repeat (5) @(posedge pclk);
        see(1'b1, 0);
        see(1'b0, 40);
        obj(32'h0001_0001);
        see(1'b1, 25);
        obj(32'h0004_0004);
        repeat (50) @(posedge pclk);
        see(1'b1, 0);
        obj(32'h0001_0000);
        see(1'b0, 3);
        obj(32'h0004_0000);
        ctl(32'h0C);
    endtask
    task automatic t_inhibit;
        obj(32'h0004_0004);
        obj(32'h0001_0001);
        see(1'b1, 3);
        ctl(32'h10C);
        obj(32'h0004_0000);
        ctl(32'h20C);
        obj(32'h0001_0000);
        see(1'b0, 3);
        ctl(32'h2C);
        ctl(32'h22C);
        obj(32'h0001_0001);
        repeat (5) @(posedge pclk);
        see(1'b0, 0);
        see(1'b1, 45);
        ctl(32'h1C);
        ctl(32'h21C);
        obj(32'h0001_0000);
        see(1'b0, 3);
        obj(32'h0004_0000);
        obj(32'h0001_0001);
        repeat (5) @(posedge pclk);
        see(1'b0, 0);
        see(1'b1, 45);
        ctl(32'h0C);
    endtask
    task automatic t_scene;
        wr(out_time_pkg::on_delay_off, 32'h0);
        wr(out_time_pkg::off_delay_off, 32'h0);
        wr(out_time_pkg::slot_base_off, 32'h18);
        ctl(32'h40C);
        rchk(out_time_pkg::slot_base_off, 32'h18);
        see(1'b1, 3);
        obj(32'h0008_1700);
        see(1'b0, 3);
        obj(32'h0001_0001);
        see(1'b1, 3);
        obj(32'h0008_9700);
        see(1'b1, 0);
        rchk(out_time_pkg::slot_base_off, 32'h218);
        obj(32'h0001_0000);
        see(1'b0, 3);
        obj(32'h0008_1700);
        see(1'b1, 3);
        ctl(32'h40C);
        rchk(out_time_pkg::slot_base_off, 32'h18);
        wr(out_time_pkg::slot_base_off + 12'h4, 32'h141);
        rchk(out_time_pkg::slot_base_off + 12'h4, 32'h300);
    endtask
    // ------------------------------------------------------------
    // Sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        presetn = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        cyc = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_delays();
        t_override();
        t_inhibit();
        t_scene();
        stop_test();
    end
endmodule

// >>> verilog/out_time_pkg.sv
package out_time_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] on_delay_off = 12'h004;
    localparam logic [11:0] off_delay_off = 12'h008;
    localparam logic [11:0] stair_time_off = 12'h00C;
    localparam logic [11:0] object_off = 12'h010;
    localparam logic [11:0] status_off = 12'h014;
    localparam logic [11:0] slot_base_off = 12'h020;
    localparam logic [11:0] slot_top_off = 12'h03C;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int ctrl_mode_bit = 0;
    localparam int ctrl_restart_bit = 1;
    localparam int ctrl_retrig_bit = 2;
    localparam int ctrl_load_def_bit = 3;
    localparam int ctrl_recov_lo = 4;
    localparam int ctrl_recov_hi = 5;
    localparam int ctrl_power_fail_bit = 8;
    localparam int ctrl_power_recover_bit = 9;
    localparam int ctrl_cfg_done_bit = 10;
    localparam logic [31:0] ctrl_reset = 32'h0000_000C;
    // ------------------------------------------------------------
    // Object write fields
    // ------------------------------------------------------------
    localparam int obj_switch_bit = 0;
    localparam int obj_perm_bit = 1;
    localparam int obj_inhibit_bit = 2;
    localparam int obj_scene_lo = 8;
    localparam int obj_scene_hi = 15;
    localparam int obj_sw_stb = 16;
    localparam int obj_perm_stb = 17;
    localparam int obj_inh_stb = 18;
    localparam int obj_scene_stb = 19;
    localparam logic [7:0] scene_store_flag = 8'h80;
    localparam logic [6:0] scene_max = 7'h40;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clk_hz = 25000000;
    localparam int tick_seconds = 1;
    localparam int tick_cycles = clk_hz * tick_seconds;
    localparam logic [15:0] delay_default = 16'h0005;
    localparam logic [15:0] stair_default = 16'h001E;
    localparam int slots = 8;
    typedef enum logic [1:0] {recov_keep, recov_inhibit, recov_enable} recov_t;
    typedef enum logic [1:0] {st_off, st_on_wait, st_on, st_off_wait} out_state_t;
endpackage

// >>> verilog/output_time_and_scene_control.sv
`timescale 1ns/100ps
module output_time_and_scene_control #(
    parameter int tick_cycles = out_time_pkg::tick_cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic relay_on
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr;
    logic slot_hit;
    logic [2:0] slot_idx;
    assign wr = psel && penable && pwrite;
    assign slot_idx = paddr[4:2];
    assign slot_hit = paddr >= out_time_pkg::slot_base_off
        && paddr <= out_time_pkg::slot_top_off && paddr[1:0] == 2'h0;
    assign pready = 1'b1;

    logic [31:0] ctrl_reg, ctrl_next;
    logic [15:0] on_delay_reg, on_delay_next;
    logic [15:0] off_delay_reg, off_delay_next;
    logic [15:0] stair_reg, stair_next;
    logic switch_reg, switch_next;
    logic perm_reg, perm_next;
    logic inhibit_reg, inhibit_next;
    logic saved_inh_reg, saved_inh_next;
    logic [6:0] slot_num_reg [out_time_pkg::slots], slot_num_next [out_time_pkg::slots];
    logic slot_def_reg [out_time_pkg::slots], slot_def_next [out_time_pkg::slots];
    logic slot_val_reg [out_time_pkg::slots], slot_val_next [out_time_pkg::slots];
    out_time_pkg::out_state_t state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic out_reg, out_next;
    logic [31:0] prdata_reg, prdata_next;

    logic tick;
    sec_prescaler #(
        .cycles(tick_cycles)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Object strobes
    // ------------------------------------------------------------
    logic obj_wr, sw_stb, perm_stb, inh_stb, scene_stb;
    logic [7:0] scene_val;
    logic pfail, precover, cfg_done, stair_mode;
    out_time_pkg::recov_t recov;
    assign obj_wr = wr && paddr == out_time_pkg::object_off;
    assign sw_stb = obj_wr && pwdata[out_time_pkg::obj_sw_stb];
    assign perm_stb = obj_wr && pwdata[out_time_pkg::obj_perm_stb];
    assign inh_stb = obj_wr && pwdata[out_time_pkg::obj_inh_stb];
    assign scene_stb = obj_wr && pwdata[out_time_pkg::obj_scene_stb];
    assign scene_val = pwdata[out_time_pkg::obj_scene_hi:out_time_pkg::obj_scene_lo];
    assign pfail = wr && paddr == out_time_pkg::ctrl_off
        && pwdata[out_time_pkg::ctrl_power_fail_bit];
    assign precover = wr && paddr == out_time_pkg::ctrl_off
        && pwdata[out_time_pkg::ctrl_power_recover_bit];
    assign cfg_done = wr && paddr == out_time_pkg::ctrl_off
        && pwdata[out_time_pkg::ctrl_cfg_done_bit];
    assign stair_mode = ctrl_reg[out_time_pkg::ctrl_mode_bit];
    assign recov = out_time_pkg::recov_t'(
        ctrl_reg[out_time_pkg::ctrl_recov_hi:out_time_pkg::ctrl_recov_lo]);

    // Scene match: recall or store of one number, value plus one
    logic [6:0] scene_num;
    logic is_store, recall_hit, recall_val;
    assign is_store = scene_val[7];
    assign scene_num = {1'b0, scene_val[5:0]} + 7'h01;
    always_comb
    begin
        recall_hit = 1'b0;
        recall_val = 1'b0;
        for (int i = 0; i < out_time_pkg::slots; i++)
        begin
            if (slot_num_reg[i] != 7'h00 && slot_num_reg[i] == scene_num)
            begin
                recall_hit = 1'b1;
                recall_val = slot_val_reg[i];
            end
        end
    end
    logic scene_valid;
    assign scene_valid = scene_stb && scene_val[6] == 1'b0;
    logic do_recall;
    assign do_recall = scene_valid && !is_store && recall_hit;

    // ------------------------------------------------------------
    // Config and object registers
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_next = ctrl_reg;
        on_delay_next = on_delay_reg;
        off_delay_next = off_delay_reg;
        stair_next = stair_reg;
        switch_next = switch_reg;
        perm_next = perm_reg;
        inhibit_next = inhibit_reg;
        saved_inh_next = saved_inh_reg;
        slot_num_next = slot_num_reg;
        slot_def_next = slot_def_reg;
        slot_val_next = slot_val_reg;
        if (wr && paddr == out_time_pkg::ctrl_off)
            ctrl_next = {26'h0000000, pwdata[5:0]};
        if (wr && paddr == out_time_pkg::on_delay_off)
            on_delay_next = pwdata[15:0];
        if (wr && paddr == out_time_pkg::off_delay_off)
            off_delay_next = pwdata[15:0];
        if (wr && paddr == out_time_pkg::stair_time_off)
            stair_next = pwdata[15:0];
        if (wr && slot_hit)
        begin
            slot_num_next[slot_idx] = (pwdata[6:0] > out_time_pkg::scene_max)
                ? 7'h00 : pwdata[6:0];
            slot_def_next[slot_idx] = pwdata[8];
        end
        if (sw_stb)
            switch_next = pwdata[out_time_pkg::obj_switch_bit];
        if (perm_stb)
            perm_next = pwdata[out_time_pkg::obj_perm_bit];
        // The inhibit object or a power-recover write (recov_enable, or recov_keep with a clear saved value) clears the inhibit
        if (inh_stb)
            inhibit_next = pwdata[out_time_pkg::obj_inhibit_bit];
        if (pfail)
            saved_inh_next = inhibit_reg;
        if (precover)
        begin
            unique case (recov)
                out_time_pkg::recov_keep: inhibit_next = saved_inh_reg;
                out_time_pkg::recov_inhibit: inhibit_next = 1'b1;
                out_time_pkg::recov_enable: inhibit_next = 1'b0;
                default: inhibit_next = inhibit_reg;
            endcase
        end
        if (scene_valid && is_store)
        begin
            for (int i = 0; i < out_time_pkg::slots; i++)
                if (slot_num_reg[i] != 7'h00 && slot_num_reg[i] == scene_num)
                    slot_val_next[i] = out_reg;
        end
        if (cfg_done && ctrl_reg[out_time_pkg::ctrl_load_def_bit])
        begin
            for (int i = 0; i < out_time_pkg::slots; i++)
                slot_val_next[i] = slot_def_reg[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= out_time_pkg::ctrl_reset;
            on_delay_reg <= out_time_pkg::delay_default;
            off_delay_reg <= out_time_pkg::delay_default;
            stair_reg <= out_time_pkg::stair_default;
            switch_reg <= 1'b0;
            perm_reg <= 1'b0;
            inhibit_reg <= 1'b0;
            saved_inh_reg <= 1'b0;
            slot_num_reg <= '{default: 7'h00};
            slot_def_reg <= '{default: 1'b1};
            slot_val_reg <= '{default: 1'b1};
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            on_delay_reg <= on_delay_next;
            off_delay_reg <= off_delay_next;
            stair_reg <= stair_next;
            switch_reg <= switch_next;
            perm_reg <= perm_next;
            inhibit_reg <= inhibit_next;
            saved_inh_reg <= saved_inh_next;
            slot_num_reg <= slot_num_next;
            slot_def_reg <= slot_def_next;
            slot_val_reg <= slot_val_next;
        end
    end

    // ------------------------------------------------------------
    // Output state machine
    // ------------------------------------------------------------
    logic cmd, cmd_val, perm_end;
    assign cmd = sw_stb || do_recall;
    assign cmd_val = do_recall ? recall_val : pwdata[out_time_pkg::obj_switch_bit];
    assign perm_end = perm_reg && perm_stb && !pwdata[out_time_pkg::obj_perm_bit];

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (tick && cnt_reg != 16'h0000)
            cnt_next = cnt_reg - 16'h0001;
        if (perm_reg && !perm_end)
        begin
            // Override holds the output on, commands during it are dropped
            state_next = out_time_pkg::st_on;
        end
        else if (perm_end)
        begin
            if (stair_mode && ctrl_reg[out_time_pkg::ctrl_restart_bit] && !inhibit_reg)
            begin
                state_next = out_time_pkg::st_on;
                cnt_next = stair_reg;
            end
            else
                state_next = out_time_pkg::st_off;
        end
        else if (cmd && (inhibit_reg || (do_recall && stair_mode && !cmd_val)))
        begin
            // Inhibited, or a stair-mode scene recall to off: the command acts at once
            state_next = cmd_val ? out_time_pkg::st_on : out_time_pkg::st_off;
            cnt_next = 16'h0000;
        end
        else if (cmd && stair_mode)
        begin
            if (cmd_val)
            begin
                if (state_reg != out_time_pkg::st_on || ctrl_reg[out_time_pkg::ctrl_retrig_bit]
                    || do_recall)
                    cnt_next = stair_reg;
                state_next = out_time_pkg::st_on;
            end
            else
                state_next = out_time_pkg::st_off;
        end
        else if (cmd)
        begin
            unique case (state_reg)
                out_time_pkg::st_off, out_time_pkg::st_off_wait:
                    if (cmd_val)
                    begin
                        state_next = out_time_pkg::st_on_wait;
                        cnt_next = on_delay_reg;
                    end
                    else if (state_reg == out_time_pkg::st_off_wait
                        && (ctrl_reg[out_time_pkg::ctrl_retrig_bit] || do_recall))
                        cnt_next = off_delay_reg;
                out_time_pkg::st_on, out_time_pkg::st_on_wait:
                    if (!cmd_val)
                    begin
                        state_next = out_time_pkg::st_off_wait;
                        cnt_next = off_delay_reg;
                    end
                    else if (state_reg == out_time_pkg::st_on_wait
                        && (ctrl_reg[out_time_pkg::ctrl_retrig_bit] || do_recall))
                        cnt_next = on_delay_reg;
            endcase
        end
        else if (cnt_next == 16'h0000 && !inhibit_reg)
        begin
            // Inhibit freezes timers, output stays where it is
            unique case (state_reg)
                out_time_pkg::st_on_wait: state_next = out_time_pkg::st_on;
                out_time_pkg::st_off_wait: state_next = out_time_pkg::st_off;
                out_time_pkg::st_on:
                    if (stair_mode && cnt_reg != 16'h0000)
                        state_next = out_time_pkg::st_off;
                out_time_pkg::st_off: state_next = out_time_pkg::st_off;
            endcase
        end
        if (inhibit_reg && !cmd && !perm_end && !perm_reg)
            cnt_next = cnt_reg;
    end

    assign out_next = state_next == out_time_pkg::st_on
        || state_next == out_time_pkg::st_off_wait;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= out_time_pkg::st_off;
            cnt_reg <= 16'h0000;
            out_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end
    assign relay_on = out_reg;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite)
        begin
            prdata_next = 32'h0000_0000;
            if (paddr == out_time_pkg::ctrl_off)
                prdata_next = ctrl_reg;
            else if (paddr == out_time_pkg::on_delay_off)
                prdata_next = {16'h0000, on_delay_reg};
            else if (paddr == out_time_pkg::off_delay_off)
                prdata_next = {16'h0000, off_delay_reg};
            else if (paddr == out_time_pkg::stair_time_off)
                prdata_next = {16'h0000, stair_reg};
            else if (paddr == out_time_pkg::object_off)
                prdata_next = {29'h00000000, inhibit_reg, perm_reg, switch_reg};
            else if (paddr == out_time_pkg::status_off)
                prdata_next = {8'h00, cnt_reg, 2'h0, state_reg, 3'h0, out_reg};
            else if (slot_hit)
                prdata_next = {22'h000000, slot_val_reg[slot_idx],
                    slot_def_reg[slot_idx], 1'b0, slot_num_reg[slot_idx]};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else
            prdata_reg <= prdata_next;
    end
    assign prdata = prdata_reg;
    assign pslverr = 1'b0;
endmodule

// >>> verilog/sec_prescaler.sv
`timescale 1ns/100ps
module sec_prescaler #(
    parameter int cycles = 25000000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [24:0] cnt_reg;
    logic [24:0] cnt_next;

    always_comb
    begin
        if (cnt_reg == 25'(cycles - 1))
            cnt_next = '0;
        else
            cnt_next = cnt_reg + 25'h0000001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    assign tick = (cnt_reg == 25'(cycles - 1));
endmodule
